// *** verilog/ptpe_core.sv ***
// Purpose: Processor stop-clock throttling, clock-control states and PM event routing
// Assumes: Register access over a simple read/write strobe port, inputs synchronous
// Notes: All outputs are registered; 32 kHz and lock-step rates come from dividers
`timescale 1ns/1ns
`default_nettype none
module ptpe_core #(
	parameter int unsigned OVERTEMP_HOLD = ptpe_pkg::OVERTEMP_HOLD_CYCLES,
	parameter int unsigned COARSE_STEP = ptpe_pkg::COARSE_STEP_CYCLES,
	parameter int unsigned BURST_SLOTS = ptpe_pkg::BURST_SLOTS_DEF
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire ptpe_pkg::ptpe_io_req_t io_req,
	output logic [15:0] io_rdata,
	output logic io_rvalid,
	input wire ptpe_pkg::ptpe_evt_t evt_in,
	input wire logic overtemp_in_n,
	input wire logic irq9_select,
	input wire logic serial_irq9,
	input wire logic pci_clock_run_in,
	output logic pci_clock_run_out,
	output logic pci_clock_run_oe,
	output logic pci_clock_stop_out_n,
	output logic stop_clock_out_n,
	output logic cache_sleep_out,
	output logic sci_out,
	output logic smi_out,
	output logic resume_out,
	output logic serial_irq_copy_out
);
	import ptpe_pkg::*;

	typedef struct packed {
		ptpe_cc_state_t cc;
		ptpe_cc_state_t prev_cc;
		ptpe_cr_state_t cr;
		logic [2:0] cr_cnt;
		logic sci_route_enable;
		logic clk_stop_en;
		logic [15:0] gp_en;
		logic [7:0] proc_ctrl;
		logic [15:0] glb_en;
		logic [7:0] count_b;
		logic nmi_gate;
		logic [4:0] flags;
		logic ot_prev;
		logic [31:0] ot_cnt;
		logic [2:0] phase;
		logic [7:0] burst_left;
		logic lock_busy;
		logic [5:0] lock_left;
		logic [15:0] rdata;
		logic rvalid;
		logic cr_out;
		logic cr_oe;
		logic pstop_n;
		logic stop_n;
		logic zz;
		logic sci;
		logic smi;
		logic resume;
		logic irq9_copy;
	} ptpe_core_state_t;

	ptpe_core_state_t q, d;
	logic slow_tick, fine_tick, coarse_tick;

	ptpe_tick #(.DIV(SLOW_CYCLES)) u_slow (
		.clk_sys(clk_sys),
		.rst(rst),
		.en(1'b1),
		.tick(slow_tick)
	);

	ptpe_tick #(.DIV(FINE_STEP_CYCLES)) u_fine (
		.clk_sys(clk_sys),
		.rst(rst),
		.en(q.lock_busy),
		.tick(fine_tick)
	);

	ptpe_tick #(.DIV(COARSE_STEP)) u_coarse (
		.clk_sys(clk_sys),
		.rst(rst),
		.en(q.lock_busy),
		.tick(coarse_tick)
	);

	function automatic logic [2:0] duty_slots(input logic [2:0] code);
		case (code)
			3'b001: duty_slots = 3'h3;
			3'b010: duty_slots = 3'h6;
			3'b011: duty_slots = 3'h5;
			3'b100: duty_slots = 3'h4;
			3'b110: duty_slots = 3'h2;
			3'b111: duty_slots = 3'h1;
			default: duty_slots = 3'h0;
		endcase
	endfunction

	logic pm_wr, pm_rd, lg_wr, lg_rd, cf_wr, cf_rd;
	logic clock_control_enable, throttle_enable, cache_sleep_enable, burst_en, bk_en, manual;
	logic level2_entry_reg_rd, level3_entry_reg_rd, ot_assert, ot_hold, therm_set, therm_end;
	logic wake, brk, burst, throttling, wave, stp_assert, lock_start, step_tick;
	logic [4:0] set5, clr5, en5, new_en;

	always_comb begin
		d = q;
		pm_wr = io_req.wr && io_req.space == SPACE_PM;
		pm_rd = io_req.rd && io_req.space == SPACE_PM;
		lg_wr = io_req.wr && io_req.space == SPACE_LEGACY;
		lg_rd = io_req.rd && io_req.space == SPACE_LEGACY;
		cf_wr = io_req.wr && io_req.space == SPACE_CFG;
		cf_rd = io_req.rd && io_req.space == SPACE_CFG;
		clock_control_enable = q.proc_ctrl[BIT_CLOCK_CONTROL_ENABLE];
		throttle_enable = q.proc_ctrl[BIT_THROTTLE_ENABLE];
		cache_sleep_enable = q.proc_ctrl[BIT_CACHE_SLEEP_ENABLE];
		burst_en = q.glb_en[BIT_BURST_EN];
		bk_en = q.glb_en[BIT_OVERTEMP_IN_BK];
		manual = clock_control_enable && throttle_enable;
		level2_entry_reg_rd = pm_rd && io_req.addr == OFS_LEVEL2;
		level3_entry_reg_rd = pm_rd && io_req.addr == OFS_LEVEL3;

		// Register writes
		clr5 = '0;
		if (pm_wr) begin
			case (io_req.addr)
				OFS_PM_CONTROL: begin
					d.sci_route_enable = io_req.wdata[BIT_SCI_ROUTE_ENABLE];
					d.clk_stop_en = io_req.wdata[BIT_CLK_STOP_EN];
				end
				OFS_GP_STATUS: clr5 = {io_req.wdata[BIT_LID], io_req.wdata[BIT_RING], io_req.wdata[BIT_GPI],
					io_req.wdata[BIT_USB], io_req.wdata[BIT_THERM]};
				OFS_GP_ENABLE: d.gp_en = io_req.wdata & GP_ENABLE_MASK;
				OFS_PROC_CTRL: d.proc_ctrl = io_req.wdata[7:0];
				OFS_GLOBAL_EN: d.glb_en = io_req.wdata & GLOBAL_EN_MASK;
				default: d.sci_route_enable = q.sci_route_enable;
			endcase
		end
		if (lg_wr && io_req.addr == OFS_NMI_PORT) begin
			d.nmi_gate = io_req.wdata[BIT_NMI];
		end
		if (cf_wr && io_req.addr == OFS_COUNT_B) begin
			d.count_b = io_req.wdata[7:0];
		end

		// Register reads, answered one cycle later
		d.rvalid = io_req.rd;
		d.rdata = 16'h0000;
		if (pm_rd) begin
			case (io_req.addr)
				OFS_PM_CONTROL: d.rdata = {14'h0000, q.clk_stop_en, q.sci_route_enable};
				OFS_GP_STATUS: begin
					d.rdata[BIT_LID] = q.flags[F_LID];
					d.rdata[BIT_RING] = q.flags[F_RING];
					d.rdata[BIT_GPI] = q.flags[F_GPI];
					d.rdata[BIT_USB] = q.flags[F_USB];
					d.rdata[BIT_THERM] = q.flags[F_THERM];
				end
				OFS_GP_ENABLE: d.rdata = q.gp_en;
				OFS_PROC_CTRL: d.rdata = {8'h00, q.proc_ctrl};
				OFS_GLOBAL_EN: d.rdata = q.glb_en;
				default: d.rdata = 16'h0000;
			endcase
		end
		if (lg_rd && io_req.addr == OFS_RTC_EXT_INDEX) begin
			d.rdata[BIT_NMI] = q.nmi_gate;
		end
		if (cf_rd && io_req.addr == OFS_COUNT_B) begin
			d.rdata = {8'h00, q.count_b};
		end
		if (cf_rd && io_req.addr == OFS_INT_PIN) begin
			d.rdata = {8'h00, INT_PIN_VALUE};
		end

		// Status flags; a set in the clear cycle wins
		ot_assert = !overtemp_in_n;
		d.ot_prev = ot_assert;
		therm_set = ot_assert && !q.ot_prev;
		set5 = {evt_in.lid, evt_in.ring, evt_in.gpi, evt_in.usb, therm_set};
		en5 = {q.gp_en[BIT_LID], q.gp_en[BIT_RING], q.gp_en[BIT_GPI], q.gp_en[BIT_USB], q.gp_en[BIT_THERM]};
		d.flags = (q.flags & ~clr5) | set5;
		new_en = set5 & ~q.flags & en5;
		d.resume = |new_en[F_LID:F_USB];
		d.sci = q.sci_route_enable && |(q.flags & en5);
		d.smi = !q.sci_route_enable && (q.flags[F_LID] && en5[F_LID] || q.flags[F_GPI] && en5[F_GPI] ||
			q.flags[F_THERM] && en5[F_THERM]);

		// Break and burst events, never held off by over-temperature
		therm_end = q.cc == ST_THERM && !ot_assert;
		wake = |new_en || evt_in.wake || (therm_end && bk_en);
		brk = wake && !burst_en;
		burst = wake && burst_en;

		// Over-temperature hold timer
		ot_hold = q.ot_cnt == OVERTEMP_HOLD;
		if (ot_assert && (q.cc == ST_GRANT || q.cc == ST_GRANT_THR || q.cc == ST_STOPCLK)) begin
			if (!ot_hold) begin
				d.ot_cnt = q.ot_cnt + 32'h1;
			end
		end else begin
			d.ot_cnt = 32'h0;
		end

		// Clock-control state machine
		lock_start = 1'b0;
		case (q.cc)
			ST_FULL: begin
				if (level2_entry_reg_rd && clock_control_enable) begin
					d.cc = ST_GRANT;
				end else if (level3_entry_reg_rd && clock_control_enable) begin
					d.cc = ST_STOPCLK;
				end
			end
			ST_GRANT: begin
				if (brk) begin
					d.cc = throttle_enable ? ST_GRANT_THR : ST_FULL;
				end else if (ot_hold) begin
					d.cc = ST_THERM;
					d.prev_cc = ST_GRANT;
				end
			end
			ST_GRANT_THR: begin
				if (!throttle_enable) begin
					d.cc = ST_FULL;
				end else if (ot_hold) begin
					d.cc = ST_THERM;
					d.prev_cc = ST_GRANT_THR;
				end
			end
			ST_STOPCLK: begin
				if (brk) begin
					d.cc = ST_FULL;
					lock_start = 1'b1;
				end else if (ot_hold) begin
					d.cc = ST_THERM;
					d.prev_cc = ST_STOPCLK;
				end
			end
			ST_THERM: begin
				if (brk) begin
					d.cc = throttle_enable ? ST_GRANT_THR : ST_FULL;
					lock_start = q.prev_cc == ST_STOPCLK;
				end else if (!ot_assert) begin
					d.cc = q.prev_cc;
				end
			end
			default: d.cc = ST_FULL;
		endcase
		if (!clock_control_enable) begin
			d.cc = ST_FULL;
		end

		// Processor lock timer after leaving stop-clock
		step_tick = q.count_b[BIT_LOCK_SEL] ? fine_tick : coarse_tick;
		if (lock_start) begin
			d.lock_busy = 1'b1;
			d.lock_left = 6'(q.count_b[4:0]) + 6'h01;
		end else if (q.lock_busy && step_tick) begin
			d.lock_left = q.lock_left - 6'h01;
			d.lock_busy = q.lock_left != 6'h01;
		end

		// Burst window of full speed
		if (burst) begin
			d.burst_left = 8'(BURST_SLOTS);
		end else if (slow_tick && q.burst_left != 8'h00) begin
			d.burst_left = q.burst_left - 8'h01;
		end

		// Throttle waveform
		if (slow_tick) begin
			d.phase = q.phase == THROTTLE_LAST_SLOT ? 3'h0 : q.phase + 3'h1;
		end
		wave = q.phase < duty_slots(q.proc_ctrl[DUTY_LSB +: 3]);
		throttling = q.cc == ST_GRANT_THR || q.cc == ST_THERM || (q.cc == ST_FULL && manual);
		stp_assert = q.lock_busy || (q.burst_left == 8'h00 &&
			(q.cc == ST_GRANT || q.cc == ST_STOPCLK || (throttling && wave)));
		d.stop_n = !stp_assert;
		d.zz = cache_sleep_enable && stp_assert;

		// PCI clock-stop request, agents deny before the fourth clock
		case (q.cr)
			CR_RUN: begin
				if (q.clk_stop_en) begin
					d.cr = CR_REQ;
				end
			end
			CR_REQ: begin
				d.cr = CR_WAIT;
				d.cr_cnt = 3'h0;
			end
			CR_WAIT: begin
				if (!pci_clock_run_in || !q.clk_stop_en) begin
					d.cr = CR_RUN;
				end else if (q.cr_cnt == PCI_CLOCK_RUN_DENY_CLKS - 3'h2) begin
					d.cr = CR_STOP;
				end else begin
					d.cr_cnt = q.cr_cnt + 3'h1;
				end
			end
			CR_STOP: begin
				if (!pci_clock_run_in || !q.clk_stop_en) begin
					d.cr = CR_RESTART;
				end
			end
			CR_RESTART: d.cr = CR_RUN;
			default: d.cr = CR_RUN;
		endcase
		d.cr_oe = d.cr == CR_RUN || d.cr == CR_REQ || d.cr == CR_RESTART;
		d.cr_out = d.cr == CR_REQ;
		d.pstop_n = d.cr != CR_STOP;

		d.irq9_copy = irq9_select && serial_irq9;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			q <= '0;
			q.gp_en <= RST_GP_ENABLE;
			q.proc_ctrl <= RST_PROC_CTRL;
			q.glb_en <= RST_GLOBAL_EN;
			q.count_b <= RST_COUNT_B;
			q.cr_oe <= 1'b1;
			q.pstop_n <= 1'b1;
			q.stop_n <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign io_rdata = q.rdata;
	assign io_rvalid = q.rvalid;
	assign pci_clock_run_out = q.cr_out;
	assign pci_clock_run_oe = q.cr_oe;
	assign pci_clock_stop_out_n = q.pstop_n;
	assign stop_clock_out_n = q.stop_n;
	assign cache_sleep_out = q.zz;
	assign sci_out = q.sci;
	assign smi_out = q.smi;
	assign resume_out = q.resume;
	assign serial_irq_copy_out = q.irq9_copy;
endmodule // ptpe_core
`default_nettype wire

// *** verilog/ptpe_pkg.sv ***
// Purpose: Shared constants and types for the processor throttle and PM event block
// Assumes: 10 MHz system clock, 32 kHz slow rate made by a divider
// Notes: Offsets are byte offsets within their access space
package ptpe_pkg;

	// Access spaces
	localparam logic [1:0] SPACE_PM = 2'h0;
	localparam logic [1:0] SPACE_LEGACY = 2'h1;
	localparam logic [1:0] SPACE_CFG = 2'h2;

	// Register offsets
	localparam logic [7:0] OFS_PM_CONTROL = 8'h04;
	localparam logic [7:0] OFS_GP_STATUS = 8'h0C;
	localparam logic [7:0] OFS_GP_ENABLE = 8'h0E;
	localparam logic [7:0] OFS_PROC_CTRL = 8'h10;
	localparam logic [7:0] OFS_LEVEL2 = 8'h14;
	localparam logic [7:0] OFS_LEVEL3 = 8'h15;
	localparam logic [7:0] OFS_GLOBAL_EN = 8'h20;
	localparam logic [7:0] OFS_NMI_PORT = 8'h70;
	localparam logic [7:0] OFS_RTC_EXT_INDEX = 8'h72;
	localparam logic [7:0] OFS_INT_PIN = 8'h3D;
	localparam logic [7:0] OFS_COUNT_B = 8'h48;

	// Field positions
	localparam int BIT_SCI_ROUTE_ENABLE = 0;
	localparam int BIT_CLK_STOP_EN = 1;
	localparam int BIT_THERM = 0;
	localparam int BIT_USB = 8;
	localparam int BIT_GPI = 9;
	localparam int BIT_RING = 10;
	localparam int BIT_LID = 11;
	localparam int BIT_CLOCK_CONTROL_ENABLE = 0;
	localparam int DUTY_LSB = 1;
	localparam int BIT_THROTTLE_ENABLE = 4;
	localparam int BIT_CACHE_SLEEP_ENABLE = 5;
	localparam int BIT_BURST_EN = 1;
	localparam int BIT_OVERTEMP_IN_BK = 2;
	localparam int BIT_NMI = 7;
	localparam int BIT_LOCK_SEL = 5;

	// Writable masks, reset values and the fixed interrupt pin value
	localparam logic [15:0] GP_ENABLE_MASK = 16'h0F01;
	localparam logic [15:0] GLOBAL_EN_MASK = 16'h0006;
	localparam logic [15:0] RST_GP_ENABLE = 16'h0000;
	localparam logic [7:0] RST_PROC_CTRL = 8'h00;
	localparam logic [15:0] RST_GLOBAL_EN = 16'h0000;
	localparam logic [7:0] RST_COUNT_B = 8'h00;
	localparam logic [7:0] INT_PIN_VALUE = 8'h00;

	// Timing
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned SLOW_PERIOD_NS = 30518;
	localparam int unsigned SLOW_CYCLES = SLOW_PERIOD_NS / CLK_PERIOD_NS;
	localparam int unsigned THROTTLE_PERIOD_US = 244;
	localparam logic [2:0] THROTTLE_LAST_SLOT = 3'h7;
	localparam int unsigned FINE_STEP_US = 8;
	localparam int unsigned FINE_STEP_CYCLES = FINE_STEP_US * 1000 / CLK_PERIOD_NS;
	localparam int unsigned COARSE_STEP_MS = 1;
	localparam int unsigned COARSE_STEP_CYCLES = COARSE_STEP_MS * 1000000 / CLK_PERIOD_NS;
	localparam int unsigned OVERTEMP_HOLD_S = 2;
	localparam int unsigned OVERTEMP_HOLD_CYCLES = OVERTEMP_HOLD_S * (1000000000 / CLK_PERIOD_NS);
	localparam logic [2:0] PCI_CLOCK_RUN_DENY_CLKS = 3'h4;
	localparam int unsigned BURST_SLOTS_DEF = 8;

	// Event flag order inside the flag vector
	localparam int F_THERM = 0;
	localparam int F_USB = 1;
	localparam int F_GPI = 2;
	localparam int F_RING = 3;
	localparam int F_LID = 4;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [1:0] space;
		logic [7:0] addr;
		logic [15:0] wdata;
	} ptpe_io_req_t;

	typedef struct packed {
		logic ring;
		logic usb;
		logic lid;
		logic gpi;
		logic wake;
	} ptpe_evt_t;

	typedef enum logic [2:0] {
		ST_FULL = 3'b000,
		ST_GRANT = 3'b001,
		ST_GRANT_THR = 3'b010,
		ST_STOPCLK = 3'b011,
		ST_THERM = 3'b100
	} ptpe_cc_state_t;

	typedef enum logic [2:0] {
		CR_RUN = 3'b000,
		CR_REQ = 3'b001,
		CR_WAIT = 3'b010,
		CR_STOP = 3'b011,
		CR_RESTART = 3'b100
	} ptpe_cr_state_t;

endpackage

// *** verilog/ptpe_tick.sv ***
// Purpose: Enable pulse divider, one pulse every DIV cycles while enabled
// Assumes: Single clock, synchronous active-high reset
// Notes: Counter restarts whenever the enable is low
`timescale 1ns/1ns
`default_nettype none
module ptpe_tick #(
	parameter int unsigned DIV = 305
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic en,
	output logic tick
);
	import ptpe_pkg::*;

	localparam int W = $clog2(DIV + 1);

	typedef struct packed {
		logic [W-1:0] cnt;
		logic tick;
	} ptpe_tick_state_t;

	ptpe_tick_state_t q, d;

	always_comb begin
		d = q;
		d.tick = 1'b0;
		if (!en) begin
			d.cnt = '0;
		end else if (q.cnt == W'(DIV - 1)) begin
			d.cnt = '0;
			d.tick = 1'b1;
		end else begin
			d.cnt = q.cnt + W'(1);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign tick = q.tick;
endmodule // ptpe_tick
`default_nettype wire

// *** tb/ptpe_checker.sv ***
// Purpose: Port-level checks for ptpe_core
// Assumes: Enable bits are shadowed from bus writes
// Notes: Bound to every ptpe_core instance
`timescale 1ns/1ns
`default_nettype none
module ptpe_checker (
	input wire logic clk_sys,
	input wire logic rst,
	input wire ptpe_pkg::ptpe_io_req_t io_req,
	input wire logic [15:0] io_rdata,
	input wire logic io_rvalid,
	input wire ptpe_pkg::ptpe_evt_t evt_in,
	input wire logic irq9_select,
	input wire logic serial_irq9,
	input wire logic pci_clock_run_in,
	input wire logic pci_clock_stop_out_n,
	input wire logic stop_clock_out_n,
	input wire logic sci_out,
	input wire logic resume_out,
	input wire logic serial_irq_copy_out
);
	import ptpe_pkg::*;
	logic sci_route_enable_q, nmi_q, lid_q, pm_wr, rd_leg, rd_pin;
	logic [15:0] general_purpose_event_enable_q;
	assign pm_wr = io_req.wr && io_req.space == SPACE_PM;
	assign rd_leg = io_req.rd && io_req.space == SPACE_LEGACY && io_req.addr == OFS_RTC_EXT_INDEX;
	assign rd_pin = io_req.rd && io_req.space == SPACE_CFG && io_req.addr == OFS_INT_PIN;
	// Shadow copies of the enables and of the lid flag
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sci_route_enable_q <= 1'b0;
			nmi_q <= 1'b0;
			lid_q <= 1'b0;
			general_purpose_event_enable_q <= 16'h0000;
		end else begin
			if (pm_wr && io_req.addr == OFS_PM_CONTROL) sci_route_enable_q <= io_req.wdata[BIT_SCI_ROUTE_ENABLE];
			if (pm_wr && io_req.addr == OFS_GP_ENABLE) general_purpose_event_enable_q <= io_req.wdata & GP_ENABLE_MASK;
			if (io_req.wr && io_req.space == SPACE_LEGACY && io_req.addr == OFS_NMI_PORT) nmi_q <= io_req.wdata[BIT_NMI];
			if (evt_in.lid) lid_q <= 1'b1;
			else if (pm_wr && io_req.addr == OFS_GP_STATUS && io_req.wdata[BIT_LID]) lid_q <= 1'b0;
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	a_read_answer: assert property (io_req.rd |=> io_rvalid) else $error("read gave no answer");
	a_ring_sci_gate: assert property (evt_in.ring && sci_route_enable_q && general_purpose_event_enable_q[BIT_RING] |-> ##2 sci_out)
		else $error("ring event gave no sci");
	a_usb_sci_gate: assert property (evt_in.usb && sci_route_enable_q && general_purpose_event_enable_q[BIT_USB] |-> ##2 sci_out)
		else $error("usb event gave no sci");
	a_lid_resume_pulse: assert property (evt_in.lid && general_purpose_event_enable_q[BIT_LID] && !lid_q |=> resume_out)
		else $error("lid event gave no resume");
	a_resume_cause: assert property (resume_out
		|-> $past(evt_in.ring || evt_in.usb || evt_in.lid || evt_in.gpi))
		else $error("resume without wake flag event");
	a_nmi_alias_read: assert property (rd_leg |=> io_rdata[BIT_NMI] == nmi_q)
		else $error("alias bit differs from nmi gate");
	a_pin_reads_zero: assert property (rd_pin |=> io_rvalid && io_rdata == 16'h0000)
		else $error("interrupt pin byte not zero");
	a_cc_clear_full: assert property (pm_wr && io_req.addr == OFS_PROC_CTRL && !io_req.wdata[BIT_CLOCK_CONTROL_ENABLE]
		|-> ##[1:3] stop_clock_out_n)
		else $error("stop clock held after cc clear");
	a_irq_copy_high: assert property (irq9_select && serial_irq9 |=> serial_irq_copy_out)
		else $error("irq copy not high");
	a_irq_copy_idle: assert property (!serial_irq9 |=> !serial_irq_copy_out)
		else $error("irq copy high while idle");
	a_pci_clock_run_no_deny: assert property ($fell(pci_clock_stop_out_n)
		|-> $past(pci_clock_run_in) && $past(pci_clock_run_in, 2))
		else $error("pci clock stopped despite denial");
	c_sci: cover property (sci_out);
	c_resume: cover property (resume_out);
	c_pci_stop: cover property (!pci_clock_stop_out_n);
endmodule // ptpe_checker
bind ptpe_core ptpe_checker chk_u (.clk_sys(clk_sys), .rst(rst), .io_req(io_req), .io_rdata(io_rdata),
	.io_rvalid(io_rvalid), .evt_in(evt_in), .irq9_select(irq9_select), .serial_irq9(serial_irq9),
	.pci_clock_run_in(pci_clock_run_in), .pci_clock_stop_out_n(pci_clock_stop_out_n),
	.stop_clock_out_n(stop_clock_out_n), .sci_out(sci_out), .resume_out(resume_out),
	.serial_irq_copy_out(serial_irq_copy_out));
`default_nettype wire

// *** tb/ptpe_pci_agent.sv ***
// Purpose: PCI agent on the shared clock-run wire
// Assumes: Wire has a pull-up, resolved in the bench
// Notes: Denies a stop request on the clock after it sees it
`timescale 1ns/1ns
`default_nettype none
module ptpe_pci_agent (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic deny,
	input wire logic run_seen,
	output logic pull_low
);
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pull_low <= 1'b0;
		end else begin
			pull_low <= deny && run_seen;
		end
	end
endmodule // ptpe_pci_agent
`default_nettype wire

// *** tb/tb.sv ***
// Purpose: Self-checking bench for ptpe_core
// Assumes: Short over-temperature hold parameter
// Notes: Duty rows in a table, the rest by hand
`timescale 1ns/1ns
`default_nettype none
module tb;
	import ptpe_pkg::*;
	localparam int PER = 8 * SLOW_CYCLES;
	localparam int CSTEP = 50;
	typedef struct {logic [2:0] duty; int slots;} ptpe_row_t;
	ptpe_row_t rows[7] = '{'{3'h1, 3}, '{3'h2, 6}, '{3'h3, 5}, '{3'h4, 4}, '{3'h5, 0}, '{3'h6, 2}, '{3'h7, 1}};
	logic [15:0] ebit[4] = '{16'h0400, 16'h0100, 16'h0800, 16'h0200};
	ptpe_evt_t evs[4] = '{5'h10, 5'h08, 5'h04, 5'h02};
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	ptpe_io_req_t io_req = '0;
	ptpe_evt_t evt_in = '0;
	logic ot_n = 1'b1, irq_sel = 1'b0, irq_in = 1'b0, deny = 1'b1;
	logic [15:0] io_rdata, rd_v;
	logic io_rvalid, run_out, run_oe, pull_low, run_wire, pstop_n, stop_n, zz, sci, smi, resume, irq_out;
	int n_fail = 0, n_tests = 0, cyc = 0;
	assign run_wire = (run_oe ? run_out : 1'b1) && !pull_low;
	ptpe_core #(.OVERTEMP_HOLD(200), .COARSE_STEP(CSTEP), .BURST_SLOTS(8)) dut_u (.clk_sys(clk_sys), .rst(rst),
		.io_req(io_req), .io_rdata(io_rdata), .io_rvalid(io_rvalid), .evt_in(evt_in), .overtemp_in_n(ot_n),
		.irq9_select(irq_sel), .serial_irq9(irq_in), .pci_clock_run_in(run_wire), .pci_clock_run_out(run_out),
		.pci_clock_run_oe(run_oe), .pci_clock_stop_out_n(pstop_n), .stop_clock_out_n(stop_n),
		.cache_sleep_out(zz), .sci_out(sci), .smi_out(smi), .resume_out(resume), .serial_irq_copy_out(irq_out));
	ptpe_pci_agent agent_u (.clk_sys(clk_sys), .rst(rst), .deny(deny), .run_seen(run_wire), .pull_low(pull_low));
	always #50 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 60000) begin
			n_fail++;
			complete_run();
		end
	end
	task automatic complete_run();
		if (n_fail == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic chkb(input string nm, input logic seen, input logic exp);
		chk(nm, {15'h0000, seen}, {15'h0000, exp});
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask
	task automatic bus(input logic w, input logic [1:0] sp, input logic [7:0] a, input logic [15:0] d);
		tick(1);
		io_req = '{rd: !w, wr: w, space: sp, addr: a, wdata: d};
		tick(1);
		io_req = '0;
		rd_v = io_rdata;
		if (!w) chkb("read valid", io_rvalid, 1'b1);
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		bus(1'b1, SPACE_PM, a, d);
	endtask
	task automatic pulse(input ptpe_evt_t e);
		evt_in = e;
		tick(1);
		evt_in = '0;
	endtask
	task automatic period(input int exp);
		int n;
		n = 0;
		repeat (PER) begin
			tick(1);
			n += (stop_n === 1'b0);
		end
		chk("stop low cycles", n[15:0], exp[15:0]);
	endtask
	initial begin
		tick(12);
		rst = 1'b0;
		bus(1'b0, SPACE_PM, OFS_GP_ENABLE, 16'h0000);
		chk("gp enable reset", rd_v, RST_GP_ENABLE);
		bus(1'b0, SPACE_PM, OFS_PROC_CTRL, 16'h0000);
		chk("proc ctrl reset", rd_v, 16'h0000);
		bus(1'b0, SPACE_PM, OFS_GLOBAL_EN, 16'h0000);
		chk("global enable reset", rd_v, RST_GLOBAL_EN);
		bus(1'b0, SPACE_CFG, OFS_INT_PIN, 16'h0000);
		chk("interrupt pin", rd_v, 16'h0000);
		bus(1'b1, SPACE_CFG, OFS_INT_PIN, 16'h00FF);
		bus(1'b0, SPACE_CFG, OFS_INT_PIN, 16'h0000);
		chk("interrupt pin ro", rd_v, 16'h0000);
		wr(OFS_GP_ENABLE, 16'hFFFF);
		bus(1'b0, SPACE_PM, OFS_GP_ENABLE, 16'h0000);
		chk("gp enable mask", rd_v, 16'h0F01);
		for (int i = 0; i < 2; i++) begin
			bus(1'b1, SPACE_LEGACY, OFS_NMI_PORT, i ? 16'h0000 : 16'h0080);
			bus(1'b0, SPACE_LEGACY, OFS_RTC_EXT_INDEX, 16'h0000);
			chkb("nmi alias", rd_v[7], i == 0);
		end
		for (int i = 0; i < 4; i++) begin
			{irq_sel, irq_in} = i[1:0];
			tick(2);
			chkb("irq copy", irq_out, i == 3);
		end
		wr(OFS_PM_CONTROL, 16'h0001);
		for (int i = 0; i < 4; i++) begin
			wr(OFS_GP_ENABLE, ebit[i]);
			pulse(evs[i]);
			chkb("resume", resume, 1'b1);
			tick(1);
			chkb("sci", sci, 1'b1);
			wr(OFS_GP_STATUS, ebit[i]);
			wr(OFS_GP_ENABLE, 16'h0000);
			pulse(evs[i]);
			tick(1);
			chkb("sci masked", sci, 1'b0);
			wr(OFS_GP_STATUS, ebit[i]);
		end
		wr(OFS_GP_ENABLE, 16'h0001);
		ot_n = 1'b0;
		tick(3);
		chkb("thermal sci", sci, 1'b1);
		ot_n = 1'b1;
		wr(OFS_GP_STATUS, 16'h0001);
		wr(OFS_GP_ENABLE, 16'h0000);
		foreach (rows[i]) begin
			wr(OFS_PROC_CTRL, {11'h000, 1'b1, rows[i].duty, 1'b1});
			tick(10);
			period(rows[i].slots * SLOW_CYCLES);
			wr(OFS_PROC_CTRL, 16'h0000);
			tick(3);
			chkb("stop released", stop_n, 1'b1);
		end
		wr(OFS_PROC_CTRL, 16'h0019);
		bus(1'b0, SPACE_PM, OFS_LEVEL2, 16'h0000);
		tick(10);
		period(PER);
		pulse(5'h01);
		tick(10);
		period(4 * SLOW_CYCLES);
		pulse(5'h01);
		tick(10);
		period(4 * SLOW_CYCLES);
		wr(OFS_PROC_CTRL, 16'h0009);
		tick(3);
		chkb("throttle off", stop_n, 1'b1);
		bus(1'b0, SPACE_PM, OFS_LEVEL2, 16'h0000);
		tick(3);
		chkb("grant", stop_n, 1'b0);
		pulse(5'h01);
		tick(10);
		period(0);
		bus(1'b0, SPACE_PM, OFS_LEVEL2, 16'h0000);
		wr(OFS_GLOBAL_EN, 16'h0002);
		pulse(5'h01);
		tick(5);
		chkb("burst run", stop_n, 1'b1);
		tick(9 * SLOW_CYCLES);
		chkb("burst back", stop_n, 1'b0);
		wr(OFS_GLOBAL_EN, 16'h0000);
		ot_n = 1'b0;
		tick(230);
		period(4 * SLOW_CYCLES);
		ot_n = 1'b1;
		tick(10);
		period(PER);
		wr(OFS_GLOBAL_EN, 16'h0004);
		ot_n = 1'b0;
		tick(230);
		ot_n = 1'b1;
		tick(10);
		period(0);
		wr(OFS_PM_CONTROL, 16'h0002);
		tick(40);
		chkb("pci stop denied", pstop_n, 1'b1);
		deny = 1'b0;
		tick(20);
		chkb("pci stop", pstop_n, 1'b0);
		wr(OFS_PM_CONTROL, 16'h0000);
		tick(5);
		chkb("pci run", pstop_n, 1'b1);
		// Lid event routed to SMI while SCI routing is off
		wr(OFS_GP_ENABLE, 16'h0800);
		pulse(5'h04);
		tick(1);
		chkb("lid smi", smi, 1'b1);
		chkb("sci routed off", sci, 1'b0);
		wr(OFS_GP_STATUS, 16'h0800);
		wr(OFS_GP_ENABLE, 16'h0000);
		tick(2);
		chkb("smi cleared", smi, 1'b0);
		// Level-3 entry, break, lock hold in fine then coarse steps
		wr(OFS_PROC_CTRL, 16'h0021);
		bus(1'b1, SPACE_CFG, OFS_COUNT_B, 16'h0022);
		bus(1'b0, SPACE_CFG, OFS_COUNT_B, 16'h0000);
		chk("count b", rd_v, 16'h0022);
		bus(1'b0, SPACE_PM, OFS_LEVEL3, 16'h0000);
		tick(3);
		chkb("stop clock", stop_n, 1'b0);
		chkb("cache sleep", zz, 1'b1);
		pulse(5'h01);
		tick(3 * FINE_STEP_CYCLES - 5);
		chkb("fine lock hold", stop_n, 1'b0);
		tick(10);
		chkb("fine lock done", stop_n, 1'b1);
		bus(1'b1, SPACE_CFG, OFS_COUNT_B, 16'h0000);
		bus(1'b0, SPACE_PM, OFS_LEVEL3, 16'h0000);
		pulse(5'h01);
		tick(CSTEP - 5);
		chkb("coarse lock hold", stop_n, 1'b0);
		tick(10);
		chkb("coarse lock done", stop_n, 1'b1);
		// Reset in mid-run while throttling and clock-stopped
		wr(OFS_PROC_CTRL, 16'h0019);
		wr(OFS_PM_CONTROL, 16'h0002);
		tick(20);
		chkb("pci stop again", pstop_n, 1'b0);
		rst = 1'b1;
		tick(2);
		rst = 1'b0;
		chkb("reset stop clock", stop_n, 1'b1);
		chkb("reset pci stop", pstop_n, 1'b1);
		chkb("reset cache sleep", zz, 1'b0);
		bus(1'b0, SPACE_PM, OFS_PROC_CTRL, 16'h0000);
		chk("reset proc ctrl", rd_v, {8'h00, RST_PROC_CTRL});
		tick(20);
		chkb("reset stop enable", pstop_n, 1'b1);
		chkb("reset no throttle", stop_n, 1'b1);
		complete_run();
	end
endmodule // tb
`default_nettype wire
